// *** hw/sbls_boot_link.sv ***
// serial write mode entry, link mode select and uart byte link
// assumes flash control sits outside: it gives security state, erase done and read data
`timescale 1ns/1ps
// Operation
// - boot_sel_a high, boot_sel_b low enters serial write
// - rx level before start picks uart or sync
// - uart: drive tx pin after communication starts
// - uart: rx pin becomes receive data line
// - bit rate follows source oscillator frequency
// - uart works from internal oscillator too
// - secured erase on internal oscillator drops link
// - unused pins keep user mode initial state
// - secured: chip erase only, reads invalid
module sbls_boot_link
    import sbls_pkg::*;
(
    // clock and reset
    input wire logic MCLK,
    input wire logic SYS_RST,
    // mode and link pins
    input wire logic BOOT_SEL_A,
    input wire logic BOOT_SEL_B,
    input wire logic PROG_RX_SELECT_PIN,
    output logic PROG_TX_PIN_O,
    output logic PROG_TX_PIN_OE,
    // clock source
    input wire sbls_osc_t OSC_RATE,
    input wire logic CR_OSC_ACTIVE,
    // flash side
    input wire logic SEC_ENABLED,
    input wire logic ERASE_DONE,
    input wire sbls_cmd_t CMD,
    output logic CMD_ACCEPT,
    output logic CMD_REJECT,
    output logic [7:0] RD_DATA,
    output logic RD_VALID,
    // byte stream
    input wire logic [7:0] TX_DATA,
    input wire logic TX_VALID,
    output logic TX_READY,
    output logic [7:0] RX_DATA,
    output logic RX_VALID,
    // status
    output logic SERIAL_WRITE_MODE,
    output logic LINK_ASYNC,
    output logic LINK_SYNC,
    output logic TRIM_LOST,
    output logic USER_PIN_INIT
);

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [2:0] pins_lvl;
    logic sel_a_lvl;
    logic sel_b_lvl;
    logic rx_lvl;

    sbls_sync3 #(.WIDTH(3)) u_sync (
        .clk(MCLK),
        .rst(SYS_RST),
        .d({PROG_RX_SELECT_PIN, BOOT_SEL_B, BOOT_SEL_A}),
        .q(pins_lvl)
    );

    assign sel_a_lvl = pins_lvl[0];
    assign sel_b_lvl = pins_lvl[1];
    assign rx_lvl = pins_lvl[2];

    // ************************************************************
    // mode selection
    // ************************************************************
    sbls_state_t state_reg;
    sbls_state_t state_next;
    logic [2:0] settle_reg;
    logic rx_prev_reg;
    logic settle_done;
    logic boot_serial;
    logic rx_fall;
    logic in_prog;
    logic trim_drop;

    assign settle_done = (settle_reg == SETTLE_CYCLES);
    assign boot_serial = sel_a_lvl & ~sel_b_lvl;
    assign rx_fall = rx_prev_reg & ~rx_lvl;
    assign in_prog = (state_reg == SBLS_ST_UART) || (state_reg == SBLS_ST_SYNC);
    // internal oscillator loses trimming on secured erase, link cannot survive
    assign trim_drop = in_prog & SEC_ENABLED & CR_OSC_ACTIVE & ERASE_DONE;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            SBLS_ST_SAMPLE: begin
                // sampled once; later boot select pin changes are ignored until reset
                if (settle_done) begin
                    if (!boot_serial) begin
                        state_next = SBLS_ST_USER;
                    end else if (rx_lvl) begin
                        state_next = SBLS_ST_SELECT;
                    end else begin
                        state_next = SBLS_ST_SYNC;
                    end
                end
            end
            SBLS_ST_USER: state_next = SBLS_ST_USER;
            SBLS_ST_SELECT: begin
                // first start bit marks start of communication
                if (rx_fall) begin
                    state_next = SBLS_ST_UART;
                end else if (!rx_lvl) begin
                    state_next = SBLS_ST_SYNC;
                end
            end
            SBLS_ST_UART: state_next = trim_drop ? SBLS_ST_DROPPED : SBLS_ST_UART;
            SBLS_ST_SYNC: state_next = trim_drop ? SBLS_ST_DROPPED : SBLS_ST_SYNC;
            SBLS_ST_DROPPED: state_next = SBLS_ST_DROPPED;
            default: state_next = SBLS_ST_SAMPLE;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            state_reg <= SBLS_ST_SAMPLE;
            settle_reg <= 3'h0;
            rx_prev_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            settle_reg <= settle_done ? settle_reg : settle_reg + 3'h1;
            rx_prev_reg <= rx_lvl;
        end
    end

    // ************************************************************
    // baud timing
    // ************************************************************
    logic [DIV_W-1:0] div_sel;

    assign div_sel = (OSC_RATE == SBLS_OSC_4MHZ) ? DIV_OSC_4MHZ :
                     (OSC_RATE == SBLS_OSC_8MHZ) ? DIV_OSC_8MHZ :
                     (OSC_RATE == SBLS_OSC_16MHZ) ? DIV_OSC_16MHZ : DIV_OSC_20MHZ;

    // ************************************************************
    // transmitter
    // ************************************************************
    logic [9:0] tx_shift_reg;
    logic [DIV_W-1:0] tx_cnt_reg;
    logic [3:0] tx_bit_reg;
    logic tx_busy_reg;
    logic tx_take;
    logic tx_tick;
    logic tx_end;

    assign tx_take = TX_VALID & TX_READY;
    assign tx_tick = tx_busy_reg & (tx_cnt_reg == '0);
    assign tx_end = tx_tick & (tx_bit_reg == FRAME_LAST_BIT);

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            tx_shift_reg <= TX_FRAME_IDLE;
            tx_cnt_reg <= '0;
            tx_bit_reg <= 4'h0;
            tx_busy_reg <= 1'b0;
        end else if (tx_take) begin
            tx_shift_reg <= {1'b1, TX_DATA, 1'b0};
            tx_cnt_reg <= div_sel - DIV_W'(1);
            tx_bit_reg <= 4'h0;
            tx_busy_reg <= 1'b1;
        end else if (tx_tick) begin
            tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
            tx_cnt_reg <= div_sel - DIV_W'(1);
            tx_bit_reg <= tx_bit_reg + 4'h1;
            tx_busy_reg <= ~tx_end;
        end else if (tx_busy_reg) begin
            tx_cnt_reg <= tx_cnt_reg - DIV_W'(1);
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            PROG_TX_PIN_O <= 1'b1;
            PROG_TX_PIN_OE <= 1'b0;
            TX_READY <= 1'b0;
        end else begin
            // pin left as an input until start so it keeps its user reset state
            PROG_TX_PIN_OE <= (state_next == SBLS_ST_UART);
            PROG_TX_PIN_O <= tx_take ? 1'b0 : (tx_tick ? tx_shift_reg[1] : tx_shift_reg[0]);
            TX_READY <= (state_next == SBLS_ST_UART) & ~tx_take & (~tx_busy_reg | tx_end);
        end
    end

    // ************************************************************
    // receiver
    // ************************************************************
    logic [7:0] rx_shift_reg;
    logic [DIV_W-1:0] rx_cnt_reg;
    logic [3:0] rx_bit_reg;
    logic rx_busy_reg;
    logic rx_start;
    logic rx_tick;
    logic rx_bad_start;
    logic rx_done;

    // the select state also listens so the first start bit is not lost
    assign rx_start = ((state_reg == SBLS_ST_SELECT) || (state_reg == SBLS_ST_UART))
                      & rx_fall & ~rx_busy_reg;
    assign rx_tick = rx_busy_reg & (rx_cnt_reg == '0);
    assign rx_bad_start = rx_tick & (rx_bit_reg == 4'h0) & rx_lvl;
    assign rx_done = rx_tick & (rx_bit_reg == FRAME_LAST_BIT);

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            rx_shift_reg <= RX_DATA_RESET;
            rx_cnt_reg <= '0;
            rx_bit_reg <= 4'h0;
            rx_busy_reg <= 1'b0;
        end else if (rx_start) begin
            rx_cnt_reg <= {1'b0, div_sel[DIV_W-1:1]}; // mid-bit sampling
            rx_bit_reg <= 4'h0;
            rx_busy_reg <= 1'b1;
        end else if (rx_tick) begin
            rx_shift_reg <= (rx_bit_reg != 4'h0 && !rx_done) ? {rx_lvl, rx_shift_reg[7:1]} :
                            rx_shift_reg;
            rx_cnt_reg <= div_sel - DIV_W'(1);
            rx_bit_reg <= rx_bit_reg + 4'h1;
            rx_busy_reg <= ~(rx_done | rx_bad_start);
        end else if (rx_busy_reg) begin
            rx_cnt_reg <= rx_cnt_reg - DIV_W'(1);
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            RX_DATA <= RX_DATA_RESET;
            RX_VALID <= 1'b0;
        end else begin
            // a low stop bit drops the byte
            // a link dropped in the same cycle delivers nothing
            RX_VALID <= rx_done & rx_lvl & (state_next == SBLS_ST_UART);
            RX_DATA <= (rx_done & rx_lvl) ? rx_shift_reg : RX_DATA;
        end
    end

    // ************************************************************
    // flash command gate and status
    // ************************************************************
    logic cmd_live;
    logic cmd_erase;
    logic cmd_read;

    assign cmd_live = CMD.valid & in_prog;
    assign cmd_erase = (CMD.op == SBLS_OP_CHIP_ERASE);
    assign cmd_read = (CMD.op == SBLS_OP_READ);

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            CMD_ACCEPT <= 1'b0;
            CMD_REJECT <= 1'b0;
            RD_DATA <= INVALID_READ_DATA;
            RD_VALID <= 1'b0;
            SERIAL_WRITE_MODE <= 1'b0;
            LINK_ASYNC <= 1'b0;
            LINK_SYNC <= 1'b0;
            TRIM_LOST <= 1'b0;
            USER_PIN_INIT <= 1'b1;
        end else begin
            CMD_ACCEPT <= cmd_live & (~SEC_ENABLED | cmd_erase);
            CMD_REJECT <= cmd_live & SEC_ENABLED & ~cmd_erase & ~cmd_read;
            RD_VALID <= cmd_live & cmd_read;
            RD_DATA <= SEC_ENABLED ? INVALID_READ_DATA : CMD.rd_data;
            SERIAL_WRITE_MODE <= (state_next != SBLS_ST_SAMPLE) && (state_next != SBLS_ST_USER);
            LINK_ASYNC <= (state_next == SBLS_ST_SELECT) || (state_next == SBLS_ST_UART);
            LINK_SYNC <= (state_next == SBLS_ST_SYNC);
            TRIM_LOST <= TRIM_LOST | trim_drop;
            USER_PIN_INIT <= 1'b1;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);

    a_serial_entry: assert property (
        state_reg == SBLS_ST_SAMPLE && settle_done && boot_serial |=> SERIAL_WRITE_MODE)
        else $error("serial write mode not entered");
    a_mode_locked: assert property (
        state_reg != SBLS_ST_SAMPLE |=> $stable(SERIAL_WRITE_MODE))
        else $error("operating mode changed after sampling");
    a_async_pick: assert property (
        $rose(LINK_SYNC) |-> $past(rx_lvl) == 1'b0)
        else $error("sync mode taken with rx high");
    a_tx_drive: assert property (
        $rose(PROG_TX_PIN_OE) |-> state_reg == SBLS_ST_UART && $past(rx_fall))
        else $error("tx driven before communication start");
    a_rx_line: assert property (
        RX_VALID |-> LINK_ASYNC && $past(state_reg) == SBLS_ST_UART)
        else $error("byte received outside uart mode");
    a_bit_time: assert property (
        tx_take |=> tx_cnt_reg == div_sel - DIV_W'(1) ##1 tx_busy_reg)
        else $error("bit period not set from oscillator rate");
    a_cr_link: assert property (
        state_reg == SBLS_ST_UART && CR_OSC_ACTIVE && !ERASE_DONE |=> PROG_TX_PIN_OE)
        else $error("link lost on internal oscillator");
    a_trim_drop: assert property (
        trim_drop |=> TRIM_LOST && !PROG_TX_PIN_OE ##1 !PROG_TX_PIN_OE)
        else $error("link kept after secured erase");
    a_pin_init: assert property (
        state_reg != SBLS_ST_UART |-> !PROG_TX_PIN_OE && USER_PIN_INIT)
        else $error("unused pin driven");
    a_secure_cmd: assert property (
        cmd_live && SEC_ENABLED && !cmd_erase |=> !CMD_ACCEPT && RD_DATA == INVALID_READ_DATA)
        else $error("secured flash command accepted");

    c_uart_byte: cover property (state_reg == SBLS_ST_UART ##1 RX_VALID);
    c_sync_mode: cover property ($rose(LINK_SYNC));
    c_secure_erase: cover property (cmd_live && SEC_ENABLED && cmd_erase);
    c_trim_drop: cover property (trim_drop);

endmodule : sbls_boot_link

// *** hw/sbls_sync3.sv ***
// three stage pin synchroniser with agreement filter
// assumes inputs are asynchronous pins; output changes only when stages 2 and 3 agree
`timescale 1ns/1ps
module sbls_sync3 #(
    parameter int WIDTH = 3
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pins in, filtered levels out
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk) begin
                if (rst) begin
                    s1_reg[i] <= 1'b0;
                    s2_reg[i] <= 1'b0;
                    s3_reg[i] <= 1'b0;
                    q[i] <= 1'b0;
                end else begin
                    s1_reg[i] <= d[i];
                    s2_reg[i] <= s1_reg[i];
                    s3_reg[i] <= s2_reg[i];
                    // stage 1 stays out of the compare to keep metastability contained
                    if (s2_reg[i] == s3_reg[i]) begin
                        q[i] <= s3_reg[i];
                    end
                end
            end
        end
    endgenerate

endmodule : sbls_sync3

// *** include/sbls_pkg.sv ***
// constants and types for the serial boot link select block
// assumes a single 10 MHz system clock and a synchronous, active high reset
package sbls_pkg;

    // ************************************************************
    // clock and baud figures
    // ************************************************************
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned BAUD_OSC_4MHZ = 9600;
    localparam int unsigned BAUD_OSC_8MHZ = 19200;
    localparam int unsigned BAUD_OSC_16MHZ = 38400;
    localparam int unsigned BAUD_OSC_20MHZ = 48000;
    localparam int DIV_W = 11;
    // cycles per bit, rounded down
    localparam logic [DIV_W-1:0] DIV_OSC_4MHZ = DIV_W'(CLK_HZ / BAUD_OSC_4MHZ);
    localparam logic [DIV_W-1:0] DIV_OSC_8MHZ = DIV_W'(CLK_HZ / BAUD_OSC_8MHZ);
    localparam logic [DIV_W-1:0] DIV_OSC_16MHZ = DIV_W'(CLK_HZ / BAUD_OSC_16MHZ);
    localparam logic [DIV_W-1:0] DIV_OSC_20MHZ = DIV_W'(CLK_HZ / BAUD_OSC_20MHZ);

    // ************************************************************
    // counts and reset values
    // ************************************************************
    localparam logic [2:0] SETTLE_CYCLES = 3'h5;
    localparam logic [3:0] FRAME_LAST_BIT = 4'h9;
    localparam logic [9:0] TX_FRAME_IDLE = 10'h3FF;
    localparam logic [7:0] INVALID_READ_DATA = 8'hFF;
    localparam logic [7:0] RX_DATA_RESET = 8'h00;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {
        SBLS_OSC_4MHZ = 2'b00,
        SBLS_OSC_8MHZ = 2'b01,
        SBLS_OSC_16MHZ = 2'b10,
        SBLS_OSC_20MHZ = 2'b11
    } sbls_osc_t;

    typedef enum logic [1:0] {
        SBLS_OP_CHIP_ERASE = 2'b00,
        SBLS_OP_SECTOR_ERASE = 2'b01,
        SBLS_OP_WRITE = 2'b10,
        SBLS_OP_READ = 2'b11
    } sbls_op_t;

    typedef struct packed {
        logic valid;
        sbls_op_t op;
        logic [7:0] rd_data;
    } sbls_cmd_t;

    typedef enum logic [2:0] {
        SBLS_ST_SAMPLE = 3'b000,
        SBLS_ST_USER = 3'b001,
        SBLS_ST_SELECT = 3'b010,
        SBLS_ST_UART = 3'b011,
        SBLS_ST_SYNC = 3'b100,
        SBLS_ST_DROPPED = 3'b101
    } sbls_state_t;

endpackage : sbls_pkg

// *** sim/sbls_boot_link_tb_top.sv ***
// self-checking bench for the serial boot link select block
// assumes the host model on the link pins; inputs change on the falling edge
`timescale 1ns/1ps
module sbls_boot_link_tb_top
    import sbls_pkg::*;
;
    // ************************************************************
    // signals and instances
    // ************************************************************
    logic mclk, sys_rst, boot_sel_a, boot_sel_b, rx_pin, cr_osc, sec, erase_done, tx_valid;
    logic tx_o, tx_oe, cmd_accept, cmd_reject, rd_valid, tx_ready, rx_valid;
    logic swm, link_async, link_sync, trim_lost, user_pin_init;
    logic [7:0] tx_data, rd_data, rx_data;
    sbls_osc_t osc;
    sbls_cmd_t cmd;
    int n_fail = 0;
    int cmp_count = 0;
    int bauds [4] = '{9600, 19200, 38400, 48000};
    // pull-up keeps the line high while the device does not drive it
    wire logic tx_line = tx_oe ? tx_o : 1'b1;

    sbls_host_model host (.clk(mclk), .tx_line(tx_line), .rx_pin(rx_pin));

    sbls_boot_link u_dut (
        .MCLK(mclk), .SYS_RST(sys_rst), .BOOT_SEL_A(boot_sel_a), .BOOT_SEL_B(boot_sel_b),
        .PROG_RX_SELECT_PIN(rx_pin), .PROG_TX_PIN_O(tx_o), .PROG_TX_PIN_OE(tx_oe),
        .OSC_RATE(osc), .CR_OSC_ACTIVE(cr_osc), .SEC_ENABLED(sec), .ERASE_DONE(erase_done),
        .CMD(cmd), .CMD_ACCEPT(cmd_accept), .CMD_REJECT(cmd_reject), .RD_DATA(rd_data),
        .RD_VALID(rd_valid), .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready),
        .RX_DATA(rx_data), .RX_VALID(rx_valid), .SERIAL_WRITE_MODE(swm),
        .LINK_ASYNC(link_async), .LINK_SYNC(link_sync), .TRIM_LOST(trim_lost),
        .USER_PIN_INIT(user_pin_init)
    );

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : check

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results

    task automatic do_reset(input logic a, input logic b, input logic lvl);
        host.set_level(lvl);
        sys_rst = 1'b1;
        boot_sel_a = a;
        boot_sel_b = b;
        repeat (10) @(negedge mclk);
        check("idle in reset", {1'b1, 10'h0, 1'b1, 8'hFF}, {tx_o, tx_oe, tx_ready, rx_valid,
            cmd_accept, cmd_reject, rd_valid, swm, link_async, link_sync, trim_lost,
            user_pin_init, rd_data});
        sys_rst = 1'b0;
        repeat (12) @(negedge mclk);
    endtask : do_reset

    // pulses may land one or two cycles after the take, so watch three
    task automatic do_cmd(input sbls_op_t op, output logic [2:0] seen, output logic [7:0] rd);
        seen = 3'b000;
        rd = 8'h00;
        cmd.op = op;
        cmd.rd_data = 8'h3C;
        cmd.valid = 1'b1;
        for (int i = 0; i < 3; i++) begin
            @(negedge mclk);
            if (i == 0)
                cmd.valid = 1'b0;
            seen |= {cmd_accept, cmd_reject, rd_valid};
            if (rd_valid === 1'b1)
                rd = rd_data;
        end
    endtask : do_cmd

    task automatic rx_byte(input logic [7:0] d, input int div, output logic [7:0] b,
                           output logic got);
        got = 1'b0;
        b = 8'h00;
        fork
            host.send(d, div);
            for (int i = 0; i < 12 * div && got !== 1'b1; i++) begin
                @(negedge mclk);
                if (rx_valid === 1'b1) begin
                    got = 1'b1;
                    b = rx_data;
                end
            end
        join
    endtask : rx_byte

    task automatic tx_byte(input logic [7:0] d);
        for (int i = 0; i < 100 && tx_ready !== 1'b1; i++) @(negedge mclk);
        tx_data = d;
        tx_valid = 1'b1;
        @(negedge mclk);
        tx_valid = 1'b0;
        check("tx busy", 1'b0, tx_ready);
    endtask : tx_byte

    task automatic erase_pulse();
        erase_done = 1'b1;
        @(negedge mclk);
        erase_done = 1'b0;
        repeat (2) @(negedge mclk);
    endtask : erase_pulse

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_modes();
        logic [5:0] tbl [4] = '{6'b000_000, 6'b110_000, 6'b101_110, 6'b100_101};
        for (int i = 0; i < 4; i++) begin
            do_reset(tbl[i][5], tbl[i][4], tbl[i][3]);
            check("mode", tbl[i][2:0], {swm, link_async, link_sync});
        end
        boot_sel_a = 1'b0;
        host.set_level(1'b1);
        repeat (20) @(negedge mclk);
        check("mode held", 3'b101, {swm, link_async, link_sync});
        $display("test modes done");
    endtask : t_modes

    task automatic t_cmds();
        logic [2:0] seen, exp;
        logic [7:0] rd;
        do_reset(1'b0, 1'b0, 1'b1);
        do_cmd(SBLS_OP_CHIP_ERASE, seen, rd);
        check("user mode cmd", 3'b000, seen);
        do_reset(1'b1, 1'b0, 1'b0);
        for (int s = 0; s < 2; s++) begin
            sec = s[0];
            for (int o = 0; o < 4; o++) begin
                do_cmd(sbls_op_t'(o), seen, rd);
                if (s == 0)
                    exp = {2'b10, o == 3};
                else
                    exp = (o == 3) ? 3'b001 : (o == 0) ? 3'b100 : 3'b010;
                check("cmd answer", exp, seen);
                if (s == 1 && o == 3)
                    check("secured read", 8'hFF, rd);
                if (s == 0 && o == 3)
                    check("plain read", 8'h3C, rd);
            end
        end
        sec = 1'b0;
        $display("test commands done");
    endtask : t_cmds

    task automatic t_uart(input sbls_osc_t r, input logic cr);
        logic [7:0] b;
        logic stop, got;
        int div, lo;
        div = 10_000_000 / bauds[r];
        osc = r;
        cr_osc = cr;
        do_reset(1'b1, 1'b0, 1'b1);
        check("tx enable before start", 1'b0, tx_oe);
        rx_byte(8'hA5, div, b, got);
        check("rx seen", 1'b1, got);
        check("rx byte", 8'hA5, b);
        check("tx enable after start", 1'b1, tx_oe);
        check("user pins", 1'b1, user_pin_init);
        fork
            host.recv(div, b, stop, lo);
            tx_byte(8'h5B);
        join
        check("tx byte", 8'h5B, b);
        check("tx stop", 1'b1, stop);
        check("bit time", div, lo);
        $display("test uart %0d done", bauds[r]);
    endtask : t_uart

    task automatic t_trim();
        logic [7:0] b;
        logic got;
        osc = SBLS_OSC_20MHZ;
        cr_osc = 1'b0;
        sec = 1'b1;
        do_reset(1'b1, 1'b0, 1'b1);
        rx_byte(8'h00, 10_000_000 / bauds[3], b, got);
        erase_pulse();
        check("crystal erase", 2'b01, {trim_lost, tx_oe});
        cr_osc = 1'b1;
        erase_pulse();
        check("cr erase", 2'b10, {trim_lost, tx_oe});
        sec = 1'b0;
        $display("test trim done");
    endtask : t_trim

    // ************************************************************
    // main sequence and watchdog
    // ************************************************************
    initial begin
        sys_rst = 1'b1;
        boot_sel_a = 1'b0;
        boot_sel_b = 1'b0;
        cr_osc = 1'b0;
        sec = 1'b0;
        erase_done = 1'b0;
        tx_valid = 1'b0;
        tx_data = 8'h00;
        osc = SBLS_OSC_20MHZ;
        cmd = '0;
        t_modes();
        t_cmds();
        // slowest rate runs from the internal oscillator alone
        for (int r = 0; r < 4; r++)
            t_uart(sbls_osc_t'(r), r == 0);
        t_trim();
        results();
    end

    // tests need about 45k cycles; allow 80k
    initial begin
        #8_000_000;
        n_fail++;
        $display("unexpected watchdog expected finish seen hang");
        results();
    end
endmodule : sbls_boot_link_tb_top

// *** sim/sbls_host_model.sv ***
// host programmer model on the far side of the line driver
// assumes the transmit line reaches it already resolved, pulled up when undriven
`timescale 1ns/1ps
module sbls_host_model (
    // clock
    input wire logic clk,
    // link lines
    input wire logic tx_line,
    output logic rx_pin
);
    // ************************************************************
    // drive side
    // ************************************************************
    initial begin
        rx_pin = 1'b1;
    end

    // level held until the first frame picks the link kind
    task automatic set_level(input logic lvl);
        @(negedge clk);
        rx_pin = lvl;
    endtask : set_level

    // 8N1, lsb first, bit time from the source oscillator rate
    task automatic send(input logic [7:0] d, input int div);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge clk);
            rx_pin = f[i];
            repeat (div - 1) @(negedge clk);
        end
    endtask : send

    // ************************************************************
    // listen side
    // ************************************************************
    // lo counts the start bit, so a wrong bit time shows directly
    task automatic recv(input int div, output logic [7:0] b, output logic stop, output int lo);
        int n;
        n = 0;
        lo = 0;
        b = 8'h00;
        while (tx_line !== 1'b0 && n < 30000) begin
            @(negedge clk);
            n++;
        end
        while (tx_line === 1'b0 && lo < 2 * div) begin
            @(negedge clk);
            lo++;
        end
        repeat (div / 2) @(negedge clk);
        for (int i = 0; i < 8; i++) begin
            b[i] = tx_line;
            repeat (div) @(negedge clk);
        end
        stop = tx_line;
    endtask : recv
endmodule : sbls_host_model
